// ===== rtl/cksw_regs.svh
// constants of the system clock switch controller
`ifndef CKSW_REGS_SVH
`define CKSW_REGS_SVH

// osc_control_reg field positions
`define CKSW_CUR_HI        14
`define CKSW_CUR_LO        12
`define CKSW_REQ_HI        10
`define CKSW_REQ_LO        8
`define CKSW_LOCK_BIT      5
`define CKSW_FAIL_BIT      3
`define CKSW_SWREQ_BIT     0
`define CKSW_CTL_RESET     16'h0000

// source select codes
`define CKSW_SRC_FRC       3'h0
`define CKSW_SRC_FRC_PLL   3'h1
`define CKSW_SRC_PRI       3'h2
`define CKSW_SRC_PRI_PLL   3'h3
`define CKSW_SRC_RSVD      3'h4
`define CKSW_SRC_LOW_POWER_RC_SOURCE      3'h5
`define CKSW_SRC_FRC_D16   3'h6
`define CKSW_SRC_FRC_DN    3'h7

// oscillator enable / clock level bit positions
`define CKSW_OSC_FRC       0
`define CKSW_OSC_PRI       1
`define CKSW_OSC_LOW_POWER_RC_SOURCE      2
`define CKSW_OSC_PLL       3

// primary submode code that needs no start-up timer
`define CKSW_SUB_EXT       2'h0

// new-clock cycles counted before the changeover
`define CKSW_NEW_CLK_WAIT  4'ha

// unlock key defaults (arbitrary values)
`define CKSW_KEY1_DEF      8'h5a
`define CKSW_KEY2_DEF      8'ha5

`endif

// ===== rtl/cksw_pkg.sv
// types of the system clock switch controller
package cksw_pkg;

	// one software write to the control register or to the unlock key
	typedef struct packed {
		logic       wr;
		logic       key;
		logic       hi;
		logic [7:0] data;
	} cksw_wr_type;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_CHECK  = 6'h02,
		ST_WAIT   = 6'h04,
		ST_COUNT  = 6'h08,
		ST_SWAP   = 6'h10,
		ST_RESUME = 6'h20
	} cksw_state_type;

endpackage

// ===== rtl/cksw_ctrl.sv
// system clock switch controller: request, start-up wait, glitch-free changeover
`timescale 1ns/1ps
`include "cksw_regs.svh"

module cksw_ctrl #(
	parameter logic [7:0] KEY1 = `CKSW_KEY1_DEF,
	parameter logic [7:0] KEY2 = `CKSW_KEY2_DEF
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire cksw_pkg::cksw_wr_type sw_wr,
	input  wire logic                 switch_enable_cfg,
	input  wire logic [2:0]           reset_source_cfg,
	input  wire logic [1:0]           primary_submode_cfg,
	input  wire logic                 watchdog_en,
	input  wire logic [3:0]           src_clk,
	input  wire logic                 ost_done,
	input  wire logic                 pll_lock,
	input  wire logic                 clk_fail,
	output logic [15:0]               osc_control_reg,
	output logic [3:0]                osc_en_reg,
	output logic [2:0]                mux_sel_reg,
	output logic                      mux_gate_reg,
	output logic                      fcy_clk_reg,
	output logic                      switch_busy_reg
);

	cksw_pkg::cksw_state_type state_reg;
	cksw_pkg::cksw_state_type state_next;
	logic [6:0]  sync1_reg;
	logic [6:0]  sync2_reg;
	logic [3:0]  clk_d_reg;
	logic [1:0]  key_reg;
	logic [1:0]  key_next;
	logic [3:0]  cnt_reg;
	logic [15:0] ctl_next;
	logic [3:0]  osc_en_next;

	// levels of the oscillator clocks are sampled, so sources must run below clock/4
	wire [3:0] clk_s      = sync2_reg[3:0];
	wire       ost_s      = sync2_reg[4];
	wire       lock_s     = sync2_reg[5];
	wire       fail_s     = sync2_reg[6];
	wire [3:0] clk_rise   = clk_s & ~clk_d_reg;
	wire       sw_on      = ~switch_enable_cfg;
	wire       fail_safe_monitor_on    = sw_on;
	wire [2:0] cur_src    = osc_control_reg[`CKSW_CUR_HI:`CKSW_CUR_LO];
	wire [2:0] req_src    = osc_control_reg[`CKSW_REQ_HI:`CKSW_REQ_LO];
	wire       swreq      = osc_control_reg[`CKSW_SWREQ_BIT];
	wire       idle       = state_reg == cksw_pkg::ST_IDLE;
	wire       armed      = key_reg == 2'h2;
	wire       reg_wr     = sw_wr.wr & ~sw_wr.key;
	wire       wr_ok      = reg_wr & armed & sw_on & idle;
	wire       hi_wr      = wr_ok & sw_wr.hi;
	wire       lo_wr      = wr_ok & ~sw_wr.hi;
	wire       redundant  = (req_src == cur_src) | (req_src == `CKSW_SRC_RSVD);
	wire       chk        = state_reg == cksw_pkg::ST_CHECK;
	wire       do_abort   = chk & redundant;
	wire       do_start   = chk & ~redundant;
	wire [3:0] need_cur   = src_need(cur_src);
	wire [3:0] need_req   = src_need(req_src);
	wire       crystal    = need_req[`CKSW_OSC_PRI] & (primary_submode_cfg != `CKSW_SUB_EXT);
	wire       use_pll    = need_req[`CKSW_OSC_PLL];
	wire       ready      = (~crystal | ost_s) & (~use_pll | lock_s);
	wire       new_edge   = clk_rise[src_idx(req_src)];
	wire       cnt_last   = cnt_reg == (`CKSW_NEW_CLK_WAIT - 4'h1);
	wire       swap_go    = (state_reg == cksw_pkg::ST_COUNT) & new_edge & cnt_last;
	wire       finish     = (state_reg == cksw_pkg::ST_RESUME) & new_edge;
	wire       low_power_rc_source_keep  = watchdog_en | fail_safe_monitor_on;
	wire       sel_edge   = clk_rise[src_idx(mux_sel_reg)];

	// enables needed by a source code; divided fast RC modes run from the fast RC
	function automatic logic [3:0] src_need(input logic [2:0] code);
		case (code)
			`CKSW_SRC_FRC_PLL: src_need = 4'h9;
			`CKSW_SRC_PRI:     src_need = 4'h2;
			`CKSW_SRC_PRI_PLL: src_need = 4'ha;
			`CKSW_SRC_LOW_POWER_RC_SOURCE:    src_need = 4'h4;
			`CKSW_SRC_RSVD:    src_need = 4'h0;
			default:           src_need = 4'h1;
		endcase
	endfunction

	// which sampled clock belongs to a source code
	function automatic logic [1:0] src_idx(input logic [2:0] code);
		case (code)
			`CKSW_SRC_FRC_PLL: src_idx = 2'h3;
			`CKSW_SRC_PRI_PLL: src_idx = 2'h3;
			`CKSW_SRC_PRI:     src_idx = 2'h1;
			`CKSW_SRC_LOW_POWER_RC_SOURCE:    src_idx = 2'h2;
			default:           src_idx = 2'h0;
		endcase
	endfunction

	// the first stage is read only by the second
	always_ff @(posedge clock) begin
		sync1_reg <= {clk_fail, pll_lock, ost_done, src_clk};
		sync2_reg <= sync1_reg;
		clk_d_reg <= sync2_reg[3:0];
	end

	// unlock keys: any other write breaks the sequence, a register write spends it
	always_comb begin
		key_next = key_reg;
		if (sw_wr.wr) begin
			key_next = 2'h0;
			if (sw_wr.key && sw_wr.data == KEY1)
				key_next = 2'h1;
			if (sw_wr.key && key_reg == 2'h1 && sw_wr.data == KEY2)
				key_next = 2'h2;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cksw_pkg::ST_IDLE: begin
				if (swreq && sw_on)
					state_next = cksw_pkg::ST_CHECK;
			end
			cksw_pkg::ST_CHECK: begin
				state_next = redundant ? cksw_pkg::ST_IDLE : cksw_pkg::ST_WAIT;
			end
			cksw_pkg::ST_WAIT: begin
				if (ready)
					state_next = cksw_pkg::ST_COUNT;
			end
			cksw_pkg::ST_COUNT: begin
				if (swap_go)
					state_next = cksw_pkg::ST_SWAP;
			end
			cksw_pkg::ST_SWAP: begin
				state_next = cksw_pkg::ST_RESUME;
			end
			cksw_pkg::ST_RESUME: begin
				if (finish)
					state_next = cksw_pkg::ST_IDLE;
			end
			default: state_next = cksw_pkg::ST_IDLE;
		endcase
		// losing the enable mid-switch returns to the reset source at once
		if (!sw_on)
			state_next = cksw_pkg::ST_IDLE;
	end

	// control register; hardware sets are applied after the clears so they win
	always_comb begin
		ctl_next = osc_control_reg;
		if (hi_wr)
			ctl_next[`CKSW_REQ_HI:`CKSW_REQ_LO] = sw_wr.data[2:0];
		if (lo_wr)
			ctl_next[`CKSW_SWREQ_BIT] = sw_wr.data[0];
		if (do_start) begin
			ctl_next[`CKSW_LOCK_BIT] = 1'b0;
			ctl_next[`CKSW_FAIL_BIT] = 1'b0;
		end
		if (lock_s && osc_en_reg[`CKSW_OSC_PLL])
			ctl_next[`CKSW_LOCK_BIT] = 1'b1;
		if (fail_s && fail_safe_monitor_on)
			ctl_next[`CKSW_FAIL_BIT] = 1'b1;
		if (do_abort || finish)
			ctl_next[`CKSW_SWREQ_BIT] = 1'b0;
		if (finish)
			ctl_next[`CKSW_CUR_HI:`CKSW_CUR_LO] = req_src;
		if (!sw_on) begin
			ctl_next[`CKSW_SWREQ_BIT] = 1'b0;
			ctl_next[`CKSW_CUR_HI:`CKSW_CUR_LO] = reset_source_cfg;
		end
		// primary submode is never stored here, only read from configuration
		osc_en_next = need_cur | (idle ? 4'h0 : need_req);
		if (low_power_rc_source_keep)
			osc_en_next[`CKSW_OSC_LOW_POWER_RC_SOURCE] = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_reg       <= cksw_pkg::ST_IDLE;
			key_reg         <= 2'h0;
			cnt_reg         <= 4'h0;
			osc_control_reg <= `CKSW_CTL_RESET;
			osc_control_reg[`CKSW_CUR_HI:`CKSW_CUR_LO] <= reset_source_cfg;
			osc_control_reg[`CKSW_REQ_HI:`CKSW_REQ_LO] <= reset_source_cfg;
			osc_en_reg      <= 4'h0;
			mux_sel_reg     <= reset_source_cfg;
			mux_gate_reg    <= 1'b0;
			fcy_clk_reg     <= 1'b0;
			switch_busy_reg <= 1'b0;
		end else begin
			state_reg       <= state_next;
			key_reg         <= key_next;
			osc_control_reg <= ctl_next;
			osc_en_reg      <= osc_en_next;
			switch_busy_reg <= ~idle;
			if (state_reg != cksw_pkg::ST_COUNT)
				cnt_reg <= 4'h0;
			else if (new_edge)
				cnt_reg <= cnt_reg + 4'h1;
			// during a switch the gate drops before the select moves and rises on a new-clock edge; with switching off, select and gate change at once
			if (!sw_on) begin
				mux_sel_reg  <= reset_source_cfg;
				mux_gate_reg <= 1'b1;
			end else if (swap_go) begin
				mux_gate_reg <= 1'b0;
			end else if (state_reg == cksw_pkg::ST_SWAP) begin
				mux_sel_reg  <= req_src;
			end else if (finish) begin
				mux_gate_reg <= 1'b1;
			end else if (idle) begin
				mux_gate_reg <= 1'b1;
			end
			if (sel_edge && mux_gate_reg)
				fcy_clk_reg <= ~fcy_clk_reg;
		end
	end

	sequence s_count_done;
		state_reg == cksw_pkg::ST_COUNT && new_edge && cnt_last;
	endsequence

	sequence s_swap_then_resume;
		state_reg == cksw_pkg::ST_SWAP ##1 state_reg == cksw_pkg::ST_RESUME;
	endsequence

	a_redundant_abort: assert property (@(posedge clock) disable iff (!reset_n)
		do_abort && sw_on |=> idle && !swreq)
		else $error("redundant request not aborted");
	a_start_clears: assert property (@(posedge clock) disable iff (!reset_n)
		do_start && !lock_s && !fail_s |=> !osc_control_reg[`CKSW_LOCK_BIT]
		&& !osc_control_reg[`CKSW_FAIL_BIT])
		else $error("lock or fail flag not cleared at start");
	a_off_no_request: assert property (@(posedge clock) disable iff (!reset_n)
		!sw_on && $past(!sw_on) |-> !swreq)
		else $error("switch request set while switching disabled");
	a_off_reports_reset: assert property (@(posedge clock) disable iff (!reset_n)
		!sw_on && $past(!sw_on) |-> cur_src == $past(reset_source_cfg))
		else $error("current source not the reset choice");
	a_pll_waits: assert property (@(posedge clock) disable iff (!reset_n)
		state_reg == cksw_pkg::ST_WAIT && use_pll && !lock_s
		|=> state_reg != cksw_pkg::ST_COUNT)
		else $error("left wait without pll lock");
	a_ost_waits: assert property (@(posedge clock) disable iff (!reset_n)
		state_reg == cksw_pkg::ST_WAIT && crystal && !ost_s
		|=> state_reg != cksw_pkg::ST_COUNT)
		else $error("left wait before start-up timer");
	a_ten_edges: assert property (@(posedge clock) disable iff (!reset_n)
		state_reg == cksw_pkg::ST_COUNT && !(new_edge && cnt_last) && sw_on
		|=> state_reg != cksw_pkg::ST_SWAP)
		else $error("changeover before ten new-clock edges");
	a_swap_order: assert property (@(posedge clock) disable iff (!reset_n)
		s_count_done and sw_on |=> !mux_gate_reg ##0 s_swap_then_resume)
		else $error("changeover sequence broken");
	a_done_update: assert property (@(posedge clock) disable iff (!reset_n)
		finish && sw_on |=> idle && !swreq && cur_src == $past(req_src)
		&& mux_gate_reg)
		else $error("completion did not update status");
	a_gate_clean: assert property (@(posedge clock) disable iff (!reset_n)
		$changed(mux_sel_reg) && sw_on && $past(sw_on) |-> !mux_gate_reg
		&& $past(!mux_gate_reg))
		else $error("mux select moved with gate open");
	a_low_power_rc_source_keep: assert property (@(posedge clock) disable iff (!reset_n)
		low_power_rc_source_keep |=> osc_en_reg[`CKSW_OSC_LOW_POWER_RC_SOURCE])
		else $error("low-power rc stopped while needed");
	a_fcy_half: assert property (@(posedge clock) disable iff (!reset_n)
		sel_edge && mux_gate_reg && $stable(mux_sel_reg)
		|=> fcy_clk_reg != $past(fcy_clk_reg))
		else $error("instruction clock did not toggle");

endmodule

// ===== tb/cksw_osc_model.sv
// oscillator sources, start-up timer and pll lock seen from the controller
`timescale 1ns/1ps
module cksw_osc_model (
	input  wire logic       clock,
	input  wire logic [3:0] osc_en,
	output logic [3:0]      src_clk,
	output logic            ost_done,
	output logic            pll_lock
);
	logic [2:0] ph_reg [4];
	logic [5:0] ost_reg;
	logic [5:0] lock_reg;

	// a stopped oscillator stands low; each source has its own slow rate
	always_ff @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			if (osc_en[i] !== 1'b1) begin
				ph_reg[i] <= 3'h0;
				src_clk[i] <= 1'b0;
			end else if (ph_reg[i] == 3'(i + 2)) begin
				ph_reg[i] <= 3'h0;
				src_clk[i] <= ~src_clk[i];
			end else begin
				ph_reg[i] <= ph_reg[i] + 3'h1;
			end
		end
		ost_reg <= (osc_en[1] !== 1'b1) ? 6'h00 : (ost_done ? ost_reg : ost_reg + 6'h01);
		lock_reg <= (osc_en[3] !== 1'b1) ? 6'h00 : (pll_lock ? lock_reg : lock_reg + 6'h01);
	end

	assign ost_done = ost_reg == 6'h28;
	assign pll_lock = lock_reg == 6'h1e;
endmodule

// ===== tb/system_clock_switch_controller_test.sv
// bench of the system clock switch controller
`timescale 1ns/1ps
`include "cksw_regs.svh"
module system_clock_switch_controller_test;
	logic                  clock;
	logic                  reset_n;
	cksw_pkg::cksw_wr_type sw_wr;
	logic                  switch_enable_cfg;
	logic                  watchdog_en;
	logic                  clk_fail;
	logic [3:0]            src_clk;
	logic                  ost_done;
	logic                  pll_lock;
	logic [15:0]           osc_control_reg;
	logic [3:0]            osc_en_reg;
	logic [2:0]            mux_sel_reg;
	logic                  mux_gate_reg;
	logic                  fcy_clk_reg;
	logic                  switch_busy_reg;
	logic [2:0]            sel_prev;
	int                    errors;
	int                    n_compared;
	int                    cycles;
	// fast rc lies between the two pll modes on purpose
	logic [2:0]            codes [10] = '{3'h0, 3'h5, 3'h3, 3'h0, 3'h1, 3'h0, 3'h6, 3'h7, 3'h2, 3'h4};

	cksw_ctrl uut (
		.clock               (clock),
		.reset_n             (reset_n),
		.sw_wr               (sw_wr),
		.switch_enable_cfg   (switch_enable_cfg),
		.reset_source_cfg    (3'h0),
		.primary_submode_cfg (2'h1),
		.watchdog_en         (watchdog_en),
		.src_clk             (src_clk),
		.ost_done            (ost_done),
		.pll_lock            (pll_lock),
		.clk_fail            (clk_fail),
		.osc_control_reg     (osc_control_reg),
		.osc_en_reg          (osc_en_reg),
		.mux_sel_reg         (mux_sel_reg),
		.mux_gate_reg        (mux_gate_reg),
		.fcy_clk_reg         (fcy_clk_reg),
		.switch_busy_reg     (switch_busy_reg)
	);

	cksw_osc_model partner (
		.clock    (clock),
		.osc_en   (osc_en_reg),
		.src_clk  (src_clk),
		.ost_done (ost_done),
		.pll_lock (pll_lock)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic put(input logic k, input logic h, input logic [7:0] d);
		@(negedge clock);
		sw_wr = '{wr: 1'b1, key: k, hi: h, data: d};
	endtask

	// every protected write needs its own fresh key pair
	task automatic prot(input logic h, input logic [7:0] d);
		put(1'b1, 1'b0, `CKSW_KEY1_DEF);
		put(1'b1, 1'b0, `CKSW_KEY2_DEF);
		put(1'b0, h, d);
		@(negedge clock);
		sw_wr.wr = 1'b0;
	endtask

	function automatic logic [3:0] need(input logic [2:0] c);
		case (c)
			3'h1: need = 4'h9;
			3'h2: need = 4'h2;
			3'h3: need = 4'ha;
			3'h5: need = 4'h4;
			default: need = 4'h1;
		endcase
	endfunction

	task automatic switch_to(input logic [2:0] code, output logic busy_seen);
		prot(1'b1, {5'h00, code});
		prot(1'b0, 8'h01);
		busy_seen = 1'b0;
		for (int i = 0; i < 3000 && (osc_control_reg[0] !== 1'b0 || i < 4); i++) begin
			@(negedge clock);
			busy_seen |= switch_busy_reg;
		end
		repeat (2) @(negedge clock);
	endtask

	// the mux select may only move while the system clock gate is shut
	always @(negedge clock) begin
		if (reset_n === 1'b1 && mux_sel_reg !== sel_prev)
			check("gate at mux change", 16'(mux_gate_reg), 16'h0000);
		sel_prev <= mux_sel_reg;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			stop_test();
		end
	end

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	initial begin
		logic [2:0] cur;
		logic [2:0] exp_cur;
		logic       busy;
		logic       f;
		int         t;
		reset_n = 1'b0;
		sw_wr = '0;
		switch_enable_cfg = 1'b1;
		watchdog_en = 1'b0;
		clk_fail = 1'b0;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (20) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		check("ctl after reset", osc_control_reg, 16'h0000);
		prot(1'b1, 8'h05);
		prot(1'b0, 8'h01);
		repeat (4) @(negedge clock);
		check("request when off", 16'(osc_control_reg[0]), 16'h0000);
		check("current when off", 16'(osc_control_reg[14:12]), 16'h0000);
		check("enables when off", 16'(osc_en_reg), 16'h0001);
		switch_enable_cfg = 1'b0;
		repeat (4) @(negedge clock);
		put(1'b0, 1'b1, 8'h03);
		@(negedge clock);
		sw_wr.wr = 1'b0;
		repeat (2) @(negedge clock);
		check("unarmed write", 16'(osc_control_reg[10:8]), 16'h0000);
		cur = 3'h0;
		for (int k = 0; k < 10; k++) begin
			exp_cur = (codes[k] == 3'h4) ? cur : codes[k];
			switch_to(codes[k], busy);
			check("current", 16'(osc_control_reg[14:12]), 16'(exp_cur));
			check("request done", 16'(osc_control_reg[0]), 16'h0000);
			check("fail flag", 16'(osc_control_reg[3]), 16'h0000);
			check("enables", 16'(osc_en_reg), 16'(need(exp_cur) | 4'h4));
			if (exp_cur != cur)
				check("busy", 16'(busy), 16'h0001);
			if (exp_cur == 3'h1 || exp_cur == 3'h3)
				check("lock", 16'(osc_control_reg[5]), 16'h0001);
			if (exp_cur == 3'h5) begin
				t = 0;
				f = fcy_clk_reg;
				repeat (200) begin
					@(negedge clock);
					if (fcy_clk_reg !== f)
						t++;
					f = fcy_clk_reg;
				end
				check("fcy toggles", 16'(t >= 19 && t <= 21), 16'h0001);
				clk_fail = 1'b1;
				repeat (6) @(negedge clock);
				clk_fail = 1'b0;
				repeat (6) @(negedge clock);
				check("fail set", 16'(osc_control_reg[3]), 16'h0001);
			end
			cur = exp_cur;
		end
		stop_test();
	end
endmodule
